/* File: hdl/uhirq_gate.sv */
// Interrupt request gating from status, enable and master gate.
// Assumes status and enable come from flip-flops on mclk.
`include "uhirq_regs.svh"
module uhirq_gate
  import uhirq_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // Event state
  input  wire logic [31:0] status,
  input  wire logic [31:0] enable,
  // Request
  output logic             irqReq
);
  localparam logic [31:0] EvtMask = `UHIRQ_EVT_MASK;
  logic [31:0] hit;

  // ******************************
  // Per-event gating
  // ******************************
  genvar g;
  generate
    for (g = 0; g < 31; g++)
    begin : gEvt
      assign hit[g] = status[g] & enable[g] & EvtMask[g];
    end
  endgenerate
  assign hit[31] = 1'b0;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      irqReq <= 1'b0;
    else
      irqReq <= (|hit) & enable[`UHIRQ_BIT_MASTER];
  end

  AST_IRQ_GATE: assert property (@(posedge mclk) disable iff (!resetn)
    irqReq |-> $past(enable[`UHIRQ_BIT_MASTER]) && $past(|(status & enable & EvtMask)))
    else $error("irq without cause");
endmodule : uhirq_gate

/* File: hdl/uhirq_pkg.sv */
// Types shared by the interrupt enable block.
// Assumes the constants header is included alongside.
package uhirq_pkg;
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } uhirq_req_type;
endpackage : uhirq_pkg

/* File: hdl/uhirq_regs.svh */
// Offsets, field positions, reset values of the interrupt enable/disable and comm area block.
// Assumes a plain register port with byte addresses and 32-bit data.
//
// Summary of operation
// - Writing one to a disable-port bit clears the matching enable bit.
// - Writing zero to a disable-port bit leaves the enable bit unchanged.
// - Reading the disable port returns the enable register; no own state.
// - Bit 31 is the master gate; one turns all interrupts off, zero ignored.
// - Hardware or software reset sets the master gate.
// - Bit 30 one stops owner change interrupts; zero ignored.
// - Bit 6 one stops hub change interrupts.
// - Bit 5 one stops frame wrap interrupts.
// - Bit 4 one stops fatal error interrupts.
// - Bit 3 one stops wake detect interrupts.
// - Bit 2 one stops frame begin interrupts.
// - Bit 1 one stops done list interrupts.
// - Bit 0 one stops scheduling overrun interrupts.
// - Comm area base bits 31..8 are software read/write, engine read only.
// - Comm area base bits 7..0 always read zero.
// - Comm area is memory shared by engine and driver.
// - Interrupt requested only when status, enable and master gate all set.
// - Writing one to an enable bit sets it; zero leaves it.
`ifndef UHIRQ_REGS_SVH
`define UHIRQ_REGS_SVH
`define UHIRQ_OFS_ENABLE    8'h10
`define UHIRQ_OFS_DISABLE   8'h14
`define UHIRQ_OFS_COMMBASE  8'h18
`define UHIRQ_OFS_CONTROL   8'h40
`define UHIRQ_BIT_MASTER    31
`define UHIRQ_BIT_OWNER     30
`define UHIRQ_EVT_MASK      32'h4000007f
`define UHIRQ_IMPL_MASK     32'hc000007f
`define UHIRQ_BASE_MASK     32'hffffff00
`define UHIRQ_ENABLE_RESET  32'h80000000
`define UHIRQ_BASE_RESET    32'h00000000
`define UHIRQ_BIT_SWRESET   0
`endif

/* File: hdl/uhirq_top.sv */
// Enable/disable interrupt register pair and comm area base pointer.
// Assumes a one-cycle strobe register port; status events come from the host engine.
`include "uhirq_regs.svh"
module uhirq_top
  import uhirq_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // Register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdata,
  // Host engine side
  input  wire logic [31:0] irqStatus,
  output logic      [31:0] irqEnable,
  output logic      [31:0] commAreaBase,
  output logic             irqReq
);
  uhirq_req_type req;
  logic [31:0] enable_q;
  logic [31:0] base_q;
  logic [31:0] rdata_q;
  logic        swReset;

  assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};
  assign swReset = req.wr && req.addr == `UHIRQ_OFS_CONTROL &&
                   req.wdata[`UHIRQ_BIT_SWRESET];

  // ******************************
  // Enable register
  // ******************************
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      enable_q <= `UHIRQ_ENABLE_RESET;
    else if (swReset)
      enable_q <= `UHIRQ_ENABLE_RESET;
    else if (req.wr && req.addr == `UHIRQ_OFS_ENABLE)
      enable_q <= enable_q | (req.wdata & `UHIRQ_IMPL_MASK);
    else if (req.wr && req.addr == `UHIRQ_OFS_DISABLE)
      // Ones clear, zeros keep, reserved ignored, covers bits 31,30,6..0
      enable_q <= enable_q & ~(req.wdata & `UHIRQ_IMPL_MASK);
  end

  // ******************************
  // Comm area base
  // ******************************
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      base_q <= `UHIRQ_BASE_RESET;
    else if (swReset)
      base_q <= `UHIRQ_BASE_RESET;
    else if (req.wr && req.addr == `UHIRQ_OFS_COMMBASE)
      base_q <= req.wdata & `UHIRQ_BASE_MASK;
  end

  // ******************************
  // Read data
  // ******************************
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      rdata_q <= 32'h00000000;
    else if (req.rd)
    begin
      case (req.addr)
        `UHIRQ_OFS_ENABLE:   rdata_q <= enable_q;
        `UHIRQ_OFS_DISABLE:  rdata_q <= enable_q;
        `UHIRQ_OFS_COMMBASE: rdata_q <= base_q;
        default:             rdata_q <= 32'h00000000;
      endcase
    end
    else
      rdata_q <= 32'h00000000;
  end

  assign regRdata     = rdata_q;
  assign irqEnable    = enable_q;
  assign commAreaBase = base_q;

  uhirq_gate uGate
  (
    .mclk   (mclk),
    .resetn (resetn),
    .status (irqStatus),
    .enable (enable_q),
    .irqReq (irqReq)
  );

  // ******************************
  // Checks
  // ******************************
  AST_DIS_CLEARS: assert property (@(posedge mclk) disable iff (!resetn)
    (regWr && regAddr == `UHIRQ_OFS_DISABLE && !swReset) |=>
    ((enable_q & $past(regWdata) & `UHIRQ_IMPL_MASK) == 32'h0))
    else $error("disable did not clear");

  AST_DIS_KEEPS: assert property (@(posedge mclk) disable iff (!resetn)
    (regWr && regAddr == `UHIRQ_OFS_DISABLE) |=>
    ((enable_q & ~$past(regWdata)) == ($past(enable_q) & ~$past(regWdata))))
    else $error("disable zero changed bit");

  AST_DIS_READ: assert property (@(posedge mclk) disable iff (!resetn)
    (regRd && regAddr == `UHIRQ_OFS_DISABLE) |=> regRdata == $past(enable_q))
    else $error("disable read mismatch");

  AST_MASTER_OFF: assert property (@(posedge mclk) disable iff (!resetn)
    (regWr && regAddr == `UHIRQ_OFS_DISABLE && regWdata[31] && !swReset) |=>
    !enable_q[31] ##1 !irqReq)
    else $error("master gate not off");

  AST_SWRESET: assert property (@(posedge mclk) disable iff (!resetn)
    swReset |=> enable_q == `UHIRQ_ENABLE_RESET)
    else $error("soft reset no gate");

  AST_OWNER_OFF: assert property (@(posedge mclk) disable iff (!resetn)
    (regWr && regAddr == `UHIRQ_OFS_DISABLE && regWdata[30]) |=> !enable_q[30])
    else $error("owner change still enabled");

  AST_HUB_OFF: assert property (@(posedge mclk) disable iff (!resetn)
    (regWr && regAddr == `UHIRQ_OFS_DISABLE && regWdata[6]) |=> !enable_q[6])
    else $error("hub change still enabled");

  AST_WRAP_OFF: assert property (@(posedge mclk) disable iff (!resetn)
    (regWr && regAddr == `UHIRQ_OFS_DISABLE && regWdata[5]) |=> !enable_q[5])
    else $error("frame wrap still enabled");

  AST_FATAL_OFF: assert property (@(posedge mclk) disable iff (!resetn)
    (regWr && regAddr == `UHIRQ_OFS_DISABLE && regWdata[4]) |=> !enable_q[4])
    else $error("fatal error still enabled");

  AST_WAKE_OFF: assert property (@(posedge mclk) disable iff (!resetn)
    (regWr && regAddr == `UHIRQ_OFS_DISABLE && regWdata[3]) |=> !enable_q[3])
    else $error("wake detect still enabled");

  AST_BEGIN_OFF: assert property (@(posedge mclk) disable iff (!resetn)
    (regWr && regAddr == `UHIRQ_OFS_DISABLE && regWdata[2]) |=> !enable_q[2])
    else $error("frame begin still enabled");

  AST_DONE_OFF: assert property (@(posedge mclk) disable iff (!resetn)
    (regWr && regAddr == `UHIRQ_OFS_DISABLE && regWdata[1]) |=> !enable_q[1])
    else $error("done list still enabled");

  AST_OVERRUN_OFF: assert property (@(posedge mclk) disable iff (!resetn)
    (regWr && regAddr == `UHIRQ_OFS_DISABLE && regWdata[0]) |=> !enable_q[0])
    else $error("overrun still enabled");

  AST_RSVD: assert property (@(posedge mclk) disable iff (!resetn)
    (enable_q & ~`UHIRQ_IMPL_MASK) == 32'h0)
    else $error("reserved bit set");

  AST_BASE_LOW: assert property (@(posedge mclk) disable iff (!resetn)
    (regRd && regAddr == `UHIRQ_OFS_COMMBASE) |=> regRdata[7:0] == 8'h00)
    else $error("base low byte nonzero");

  AST_BASE_WR: assert property (@(posedge mclk) disable iff (!resetn)
    (regWr && regAddr == `UHIRQ_OFS_COMMBASE) |=>
    base_q[31:8] == $past(regWdata[31:8]))
    else $error("base not stored");

  AST_EN_SET: assert property (@(posedge mclk) disable iff (!resetn)
    (regWr && regAddr == `UHIRQ_OFS_ENABLE) |=>
    ((~enable_q & $past(regWdata) & `UHIRQ_IMPL_MASK) == 32'h0))
    else $error("enable set failed");

  COV_DISABLE: cover property (@(posedge mclk) regWr && regAddr == `UHIRQ_OFS_DISABLE);
  COV_IRQ:     cover property (@(posedge mclk) irqReq);
  COV_BASE:    cover property (@(posedge mclk) regRd && regAddr == `UHIRQ_OFS_COMMBASE);
  COV_SWRST:   cover property (@(posedge mclk) swReset);
  COV_MOFF:    cover property (@(posedge mclk) irqReq ##1 !enable_q[31]);
endmodule : uhirq_top

/* File: verif/uhirq_top_tb.sv */
// Self-checking bench for the enable/disable pair and the comm area base.
// Assumes the design files and the constants header are compiled first.
`include "uhirq_regs.svh"
module uhirq_top_tb
  import uhirq_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk, resetn, regWr, regRd, irqReq;
  logic [7:0]  regAddr;
  logic [31:0] regWdata, regRdata, irqStatus, irqEnable, commAreaBase;
  logic [31:0] enM, baseM, v;
  int          errorCnt, comparisons, i;
  integer      seed;
  int          bitList [9] = '{31, 30, 6, 5, 4, 3, 2, 1, 0};

  uhirq_top u_dut (.mclk(mclk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irqStatus(irqStatus),
    .irqEnable(irqEnable), .commAreaBase(commAreaBase), .irqReq(irqReq));

  always #2 mclk = ~mclk;

  // ****
  // Tasks
  // ****
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errorCnt++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
    if (a == `UHIRQ_OFS_ENABLE) enM = enM | (d & `UHIRQ_IMPL_MASK);
    if (a == `UHIRQ_OFS_DISABLE) enM = enM & ~d;
    if (a == `UHIRQ_OFS_COMMBASE) baseM = d & `UHIRQ_BASE_MASK;
    if (a == `UHIRQ_OFS_CONTROL && d[`UHIRQ_BIT_SWRESET])
    begin
      enM   = `UHIRQ_ENABLE_RESET;
      baseM = `UHIRQ_BASE_RESET;
    end
    @(posedge mclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 chk(regRdata, exp);
    @(posedge mclk);
  endtask : rd

  task automatic finishTest();
    $display("errors %0d comparisons %0d", errorCnt, comparisons);
    if (errorCnt == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finishTest

  // ****
  // Main sequence
  // ****
  initial
  begin
    seed = 32'hf0f6;
    mclk = 1'b0;
    resetn = 1'b0;
    regAddr = 8'h00;
    regWdata = 32'h0;
    regWr = 1'b0;
    regRd = 1'b0;
    irqStatus = 32'h0;
    enM = `UHIRQ_ENABLE_RESET;
    baseM = `UHIRQ_BASE_RESET;
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    rd(`UHIRQ_OFS_DISABLE, enM);
    rd(`UHIRQ_OFS_COMMBASE, baseM);
    $display("test reset values done");
    for (i = 0; i < 9; i++)
    begin
      wr(`UHIRQ_OFS_ENABLE, 32'hffffffff);
      wr(`UHIRQ_OFS_DISABLE, 32'h1 << bitList[i]);
      rd(`UHIRQ_OFS_DISABLE, enM);
      chk(irqEnable, enM);
    end
    $display("test per bit disable done");
    repeat (40)
    begin
      v = $random(seed);
      irqStatus <= $random(seed);
      wr(v[0] ? `UHIRQ_OFS_ENABLE : `UHIRQ_OFS_DISABLE, $random(seed));
      rd(`UHIRQ_OFS_DISABLE, enM);
      repeat (2) @(posedge mclk);
      #1 chk({31'h0, irqReq}, {31'h0, (|(irqStatus & enM & `UHIRQ_EVT_MASK)) & enM[31]});
      @(posedge mclk);
    end
    $display("test random enable and request done");
    wr(`UHIRQ_OFS_COMMBASE, 32'hffffffff);
    rd(`UHIRQ_OFS_COMMBASE, baseM);
    wr(`UHIRQ_OFS_COMMBASE, $random(seed));
    rd(`UHIRQ_OFS_COMMBASE, baseM);
    chk(commAreaBase, baseM);
    rd(8'h20, 32'h0);
    wr(8'h20, 32'hffffffff);
    rd(`UHIRQ_OFS_DISABLE, enM);
    $display("test comm base and unmapped done");
    wr(`UHIRQ_OFS_CONTROL, 32'h1);
    rd(`UHIRQ_OFS_DISABLE, enM);
    rd(`UHIRQ_OFS_COMMBASE, baseM);
    wr(`UHIRQ_OFS_DISABLE, 32'hffffffff);
    wr(`UHIRQ_OFS_COMMBASE, 32'h12345678);
    resetn <= 1'b0;
    enM = `UHIRQ_ENABLE_RESET;
    baseM = `UHIRQ_BASE_RESET;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    rd(`UHIRQ_OFS_DISABLE, enM);
    rd(`UHIRQ_OFS_COMMBASE, baseM);
    chk({31'h0, irqReq}, 32'h0);
    $display("test resets done");
    finishTest();
  end

  initial
  begin
    repeat (20000) @(posedge mclk);
    errorCnt++;
    finishTest();
  end
endmodule : uhirq_top_tb
